//--- rtl/otc_regs.svh
// Register map and constants of the odd timer control block
// Assumes inclusion by the prescaler and timer control design files of this block
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH
// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define OTC_ADDR_CTRL      4'h0
`define OTC_ADDR_STATUS    4'h1
`define OTC_BIT_RUN        15
`define OTC_BIT_IDLE       13
`define OTC_BIT_GATE       6
`define OTC_BIT_PS_HI      5
`define OTC_BIT_PS_LO      4
`define OTC_BIT_SRC        1
`define OTC_CTRL_MASK      16'ha072
`define OTC_CTRL_RESET     16'h0000
`define OTC_PS_DIV1        8'h00
`define OTC_PS_DIV8        8'h07
`define OTC_PS_DIV64       8'h3f
`define OTC_PS_DIV256      8'hff
`endif

//--- rtl/otc_pkg.sv
// Types shared by the odd timer control block
// Assumes the constants header sits beside it
package otc_pkg;
  typedef logic [15:0] otc_word_t;
  typedef logic [3:0]  otc_addr_t;
  typedef enum logic [1:0] {OTC_PS_1, OTC_PS_8, OTC_PS_64, OTC_PS_256} otc_ps_t;
endpackage

//--- rtl/otc_prescaler.sv
// Input prescaler: emits a tick every 1, 8, 64 or 256 input events
// Assumes a synchronous single-cycle event input
`include "otc_regs.svh"
module otc_prescaler
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    nrst,
  // Control
  input  wire otc_ps_t sel,
  input  wire logic    clr,
  input  wire logic    event_in,
  // Result
  output logic         tick
);
  import otc_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;
  logic       wrap;

  // Terminal count per prescale code
  assign limit = (sel == OTC_PS_1)  ? `OTC_PS_DIV1 :
                 (sel == OTC_PS_8)  ? `OTC_PS_DIV8 :
                 (sel == OTC_PS_64) ? `OTC_PS_DIV64 : `OTC_PS_DIV256;
  assign wrap  = event_in && (cnt_q >= limit);
  assign cnt_d = clr ? 8'h00 : wrap ? 8'h00 : event_in ? cnt_q + 8'h01 : cnt_q;
  assign tick  = wrap && !clr;

  // Event counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_q <= 8'h00;
    else       cnt_q <= cnt_d;
  end
endmodule

//--- rtl/otc_timer_ctrl.sv
// Odd timer control register and its mode logic
// Assumes a single-cycle software port; external pins are asynchronous
`include "otc_regs.svh"
module otc_timer_ctrl
  import otc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Software port
  input  wire otc_addr_t  addr,
  input  wire otc_word_t  wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output otc_word_t       rdata,
  // Device context
  input  wire logic       pair_wide_mode,
  input  wire logic       idle_mode,
  // External pins
  input  wire logic       external_count_pin,
  input  wire logic       gate_pin,
  // Timer outputs
  output otc_word_t       count,
  output logic            count_tick
);
  import otc_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  otc_word_t odd_timer_control_q;
  otc_word_t rdata_q;
  otc_word_t rdata_d;
  otc_word_t count_q;
  logic      tick_q;
  logic      wr_ctrl;
  logic      timer_run;
  logic      halt_in_idle;
  logic      gated_accum_enable;
  logic      clock_source_sel;
  otc_ps_t   input_prescale_sel;

  assign wr_ctrl = wr && (addr == `OTC_ADDR_CTRL);

  // Control register, only implemented bits stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) odd_timer_control_q <= `OTC_CTRL_RESET;
    else if (wr_ctrl) odd_timer_control_q <= wdata & `OTC_CTRL_MASK;
  end

  // Field decode
  assign timer_run          = odd_timer_control_q[`OTC_BIT_RUN];
  assign halt_in_idle       = odd_timer_control_q[`OTC_BIT_IDLE];
  assign gated_accum_enable = odd_timer_control_q[`OTC_BIT_GATE];
  assign clock_source_sel   = odd_timer_control_q[`OTC_BIT_SRC];
  assign input_prescale_sel = otc_ps_t'(odd_timer_control_q[`OTC_BIT_PS_HI:`OTC_BIT_PS_LO]);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic gate_s1_q;
  logic gate_s2_q;
  logic ext_rise;
  logic [2:0] ext_fill_q;

  // Two flops per pin, third flop on the external count pin only for edge detect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_s3_q   <= 1'b0;
      gate_s1_q  <= 1'b0;
      gate_s2_q  <= 1'b0;
      ext_fill_q <= 3'b000;
    end else begin
      ext_s1_q   <= external_count_pin;
      ext_s2_q   <= ext_s1_q;
      ext_s3_q   <= ext_s2_q;
      gate_s1_q  <= gate_pin;
      gate_s2_q  <= gate_s1_q;
      ext_fill_q <= {ext_fill_q[1:0], 1'b1};
    end
  end

  // Edges ignored until the pin chain holds real samples
  // A pin idling high would otherwise fake one edge after reset
  assign ext_rise = ext_s2_q && !ext_s3_q && ext_fill_q[2];

  // ****************************************************************
  // Count enable
  // ****************************************************************
  logic own_mode;
  logic active;
  logic src_event;
  logic ps_tick;

  assign own_mode  = !pair_wide_mode;
  assign active    = own_mode && timer_run
                     && !(idle_mode && halt_in_idle);
  // Internal clock counts always, or only while gate high when gated
  assign src_event = clock_source_sel ? ext_rise
                   : (gated_accum_enable ? gate_s2_q : 1'b1);

  otc_prescaler u_ps (
    .clk      (clk),
    .nrst     (nrst),
    .sel      (input_prescale_sel),
    .clr      (!active),
    .event_in (src_event && active),
    .tick     (ps_tick)
  );

  // Timer counter and tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 16'h0000;
      tick_q  <= 1'b0;
    end else begin
      count_q <= ps_tick ? count_q + 16'h0001 : count_q;
      tick_q  <= ps_tick;
    end
  end

  assign count      = count_q;
  assign count_tick = tick_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign rdata_d = !rd ? 16'h0000
                 : (addr == `OTC_ADDR_CTRL)   ? odd_timer_control_q
                 : (addr == `OTC_ADDR_STATUS) ? count_q : 16'h0000;

  // Read data register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_q <= 16'h0000;
    else       rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_unimpl_zero: assert property (@(posedge clk) disable iff (!nrst)
    (odd_timer_control_q & ~`OTC_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bits set");

  a_stop_holds: assert property (@(posedge clk) disable iff (!nrst)
    !timer_run |=> $stable(count_q))
    else $error("counter moved while stopped");

  a_wide_holds: assert property (@(posedge clk) disable iff (!nrst)
    pair_wide_mode |=> $stable(count_q))
    else $error("counter moved in wide mode");

  a_idle_halt: assert property (@(posedge clk) disable iff (!nrst)
    (idle_mode && halt_in_idle) |=> !tick_q)
    else $error("counted while halted in idle");

  a_div1_rate: assert property (@(posedge clk) disable iff (!nrst)
    (active && !clock_source_sel && !gated_accum_enable
     && input_prescale_sel == OTC_PS_1) |=> tick_q)
    else $error("divide by one missed a tick");

  a_gate_low: assert property (@(posedge clk) disable iff (!nrst)
    (!clock_source_sel && gated_accum_enable && !gate_s2_q) |=> !tick_q)
    else $error("counted with gate low");

  a_ext_edge: assert property (@(posedge clk) disable iff (!nrst)
    (clock_source_sel && !ext_rise) |=> !tick_q)
    else $error("external count without edge");

  a_div8_gap: assert property (@(posedge clk) disable iff (!nrst)
    (tick_q && input_prescale_sel == OTC_PS_8 && $stable(odd_timer_control_q))
    |-> ##1 !tick_q [*7])
    else $error("divide by eight ticked early");

  a_write_read: assert property (@(posedge clk) disable iff (!nrst)
    (wr_ctrl) |=> odd_timer_control_q == ($past(wdata) & `OTC_CTRL_MASK))
    else $error("control write not stored");

  // Read data only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !rd |=> rdata_q == 16'h0000)
    else $error("read data without read strobe");

  // Each tick advances the counter by exactly one
  a_tick_step: assert property (@(posedge clk) disable iff (!nrst)
    tick_q |-> count_q == $past(count_q) + 16'h0001)
    else $error("counter step not one");

  a_wide_quiet: assert property (@(posedge clk) disable iff (!nrst)
    pair_wide_mode |=> !tick_q)
    else $error("tick in wide mode");

  // External edges count whatever the gate bit says
  a_ext_no_gate: assert property (@(posedge clk) disable iff (!nrst)
    (active && clock_source_sel && ext_rise && input_prescale_sel == OTC_PS_1)
    |=> tick_q)
    else $error("external edge lost");

  a_gate_high: assert property (@(posedge clk) disable iff (!nrst)
    (active && !clock_source_sel && gated_accum_enable && gate_s2_q
     && input_prescale_sel == OTC_PS_1) |=> tick_q)
    else $error("gated count missed with gate high");

  // Idle alone does not stop the timer when halt bit is clear
  a_idle_runs: assert property (@(posedge clk) disable iff (!nrst)
    (own_mode && timer_run && idle_mode && !halt_in_idle && !clock_source_sel
     && !gated_accum_enable && input_prescale_sel == OTC_PS_1) |=> tick_q)
    else $error("stopped in idle with halt bit clear");
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the odd timer control block
// Assumes the package and the constants header are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import otc_pkg::*;
  // ****
  // Stimulus and checking
  // ****
  typedef struct {otc_word_t ctrl; logic idl; logic wid; logic gat; logic ex; int exp;} otc_row_t;
  logic      clk, nrst, wr, rd, wide, idle, ext, gate, ext_on, tick;
  otc_addr_t addr;
  otc_word_t wdata, rdata, count, d, c0, delta;
  int        n_fail, cmp_count, cyc;
  otc_row_t  rows[13] = '{
    '{16'h8000, 0, 0, 0, 0, 512}, '{16'h8010, 0, 0, 0, 0, 64},
    '{16'h8020, 0, 0, 0, 0, 8}, '{16'h8030, 0, 0, 0, 0, 2},
    '{16'h0030, 0, 0, 0, 0, 0}, '{16'ha000, 1, 0, 0, 0, 0},
    '{16'h8000, 1, 0, 0, 0, 512}, '{16'h8000, 0, 1, 0, 0, 0},
    '{16'h8040, 0, 0, 0, 0, 0}, '{16'h8040, 0, 0, 1, 0, 512},
    '{16'h8042, 0, 0, 0, 1, 64}, '{16'h8052, 0, 0, 0, 1, 8},
    '{16'ha002, 0, 1, 1, 1, 0}};
  otc_timer_ctrl i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pair_wide_mode(wide), .idle_mode(idle), .external_count_pin(ext),
    .gate_pin(gate), .count(count), .count_tick(tick));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // External pin: one rising edge every 8 cycles while enabled
  always begin
    repeat (4) @(posedge clk);
    if (ext_on) ext <= ~ext;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic check(input otc_word_t seen, input otc_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input otc_addr_t a, input otc_word_t v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input otc_addr_t a, output otc_word_t v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    {nrst, wr, rd, wide, idle, ext, gate, ext_on} = '0;
    addr = '0;
    wdata = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(4'h0, d);
    check(d, 16'h0000);
    // Counting rows: delta of count over 512 cycles, two counts of slack
    foreach (rows[i]) begin
      @(posedge clk);
      {idle, wide, gate, ext_on} <= {rows[i].idl, rows[i].wid, rows[i].gat, rows[i].ex};
      #1 c0 = count;
      wr_reg(4'h0, rows[i].ctrl);
      repeat (512) @(posedge clk);
      wr_reg(4'h0, 16'h0000);
      ext_on <= 1'b0;
      repeat (6) @(posedge clk);
      #1 delta = count - c0;
      check(otc_word_t'(delta + 2 >= rows[i].exp && delta <= rows[i].exp + 2
                        && (delta != 0) == (rows[i].exp != 0)), 16'h1);
    end
    {idle, wide, gate} <= 3'b000;
    // Unimplemented bits, back-to-back write then read
    wr_reg(4'h0, 16'hffff);
    rd_reg(4'h0, d);
    check(d, 16'ha072);
    @(posedge clk);
    wdata <= 16'h5f8d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1 check(rdata, 16'h0000);
    // Write elsewhere leaves control alone; unmapped read is zero
    wr_reg(4'h1, 16'h8030);
    rd_reg(4'h0, d);
    check(d, 16'h0000);
    rd_reg(4'h5, d);
    check(d, 16'h0000);
    rd_reg(4'h1, d);
    check(d, count);
    // Reset in mid-run clears control and counter
    wr_reg(4'h0, 16'h8000);
    repeat (20) @(posedge clk);
    #1 check(otc_word_t'(tick), 16'h0001);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    check(count, 16'h0000);
    check(otc_word_t'(tick), 16'h0000);
    nrst <= 1'b1;
    rd_reg(4'h0, d);
    check(d, 16'h0000);
    end_of_test();
  end
endmodule
